// File: port_clock_gating.sv
// AHB-Lite register block gating the clocks of eight ports
// What this block does
// - one enable bit per port, A at 0
// - set enable bit clocks the port
// - clear enable bit stops the port clock
// - access to gated port gives bus fault
// - all enable bits reset to zero
// - run register governs normal running
// - mode registers used only with auto gating
`timescale 1ns/1ps
module port_clock_gating #(
  parameter int PORTS = port_gate_pkg::PORT_COUNT
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESET_N,
  // ahb-lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // power mode from the core
  input wire port_gate_pkg::power_mode_t POWER_MODE,
  // port side
  output logic [PORTS-1:0] PORT_CLOCK_ENABLE,
  input wire logic [PORTS-1:0] PORT_ACCESS,
  output logic PORT_BUS_FAULT,
  // interrupt
  output logic IRQ
);
  port_gate_pkg::bus_req_t req;
  port_gate_pkg::bus_req_t next_req;
  logic [PORTS-1:0] run_port_clock_gate;
  logic [PORTS-1:0] next_run;
  logic [PORTS-1:0] sleep_port_clock_gate;
  logic [PORTS-1:0] next_sleep;
  logic [PORTS-1:0] deep_sleep_port_clock_gate;
  logic [PORTS-1:0] next_deep;
  logic auto_clock_gating_select;
  logic next_auto;
  logic [port_gate_pkg::IRQ_BITS-1:0] irq_status;
  logic [port_gate_pkg::IRQ_BITS-1:0] next_irq_status;
  logic [port_gate_pkg::IRQ_BITS-1:0] irq_enable;
  logic [port_gate_pkg::IRQ_BITS-1:0] next_irq_enable;
  logic [31:0] next_rdata;
  logic [31:0] rdata;
  logic [PORTS-1:0] active_gate;
  logic [PORTS-1:0] enable_q;
  logic fault;
  logic fault_q;
  logic mode_change;
  port_gate_pkg::power_mode_t mode_q;
  logic [PORTS-1:0] access_s1;
  logic [PORTS-1:0] access_s2;

  port_gate_select #(.PORTS(PORTS)) port_gate_select_i (
    .run_gate(run_port_clock_gate),
    .sleep_gate(sleep_port_clock_gate),
    .deep_gate(deep_sleep_port_clock_gate),
    .auto_gating(auto_clock_gating_select),
    .mode(POWER_MODE),
    .active_gate(active_gate)
  );

  port_fault_check #(.PORTS(PORTS)) port_fault_check_i (
    .access(access_s2),
    .active_gate(active_gate),
    .fault(fault)
  );

  // address phase capture and register writes
  always_comb begin
    next_req.sel = HSEL && HREADY && HTRANS[1];
    next_req.write = HWRITE;
    next_req.addr = HADDR[11:0];
    next_run = run_port_clock_gate;
    next_sleep = sleep_port_clock_gate;
    next_deep = deep_sleep_port_clock_gate;
    next_auto = auto_clock_gating_select;
    next_irq_enable = irq_enable;
    next_irq_status = irq_status;
    if (req.sel && req.write) begin
      case (req.addr)
        port_gate_pkg::RUN_PORT_CLOCK_GATE_OFF: next_run = HWDATA[PORTS-1:0];
        port_gate_pkg::SLEEP_PORT_CLOCK_GATE_OFF: next_sleep = HWDATA[PORTS-1:0];
        port_gate_pkg::DEEP_SLEEP_PORT_CLOCK_GATE_OFF: next_deep = HWDATA[PORTS-1:0];
        port_gate_pkg::RUN_CLOCK_CONFIGURATION_OFF:
          next_auto = HWDATA[port_gate_pkg::AUTO_CLOCK_GATING_POS];
        port_gate_pkg::IRQ_ENABLE_OFF:
          next_irq_enable = HWDATA[port_gate_pkg::IRQ_BITS-1:0];
        port_gate_pkg::IRQ_CLEAR_OFF:
          next_irq_status = irq_status & ~HWDATA[port_gate_pkg::IRQ_BITS-1:0];
        default: next_irq_status = irq_status;
      endcase
    end
    // set wins over a clear in the same cycle
    if (fault) begin
      next_irq_status[port_gate_pkg::IRQ_FAULT_POS] = 1'b1;
    end
    if (mode_change) begin
      next_irq_status[port_gate_pkg::IRQ_MODE_POS] = 1'b1;
    end
  end

  // read data mux, upper bits zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (next_req.sel && !HWRITE) begin
      case (HADDR[11:0])
        port_gate_pkg::RUN_PORT_CLOCK_GATE_OFF: next_rdata[PORTS-1:0] = run_port_clock_gate;
        port_gate_pkg::SLEEP_PORT_CLOCK_GATE_OFF: next_rdata[PORTS-1:0] = sleep_port_clock_gate;
        port_gate_pkg::DEEP_SLEEP_PORT_CLOCK_GATE_OFF:
          next_rdata[PORTS-1:0] = deep_sleep_port_clock_gate;
        port_gate_pkg::RUN_CLOCK_CONFIGURATION_OFF:
          next_rdata[port_gate_pkg::AUTO_CLOCK_GATING_POS] = auto_clock_gating_select;
        port_gate_pkg::IRQ_STATUS_OFF: next_rdata[port_gate_pkg::IRQ_BITS-1:0] = irq_status;
        port_gate_pkg::IRQ_ENABLE_OFF: next_rdata[port_gate_pkg::IRQ_BITS-1:0] = irq_enable;
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  assign mode_change = (POWER_MODE != mode_q);

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      req <= '0;
      run_port_clock_gate <= port_gate_pkg::GATE_RESET;
      sleep_port_clock_gate <= port_gate_pkg::GATE_RESET;
      deep_sleep_port_clock_gate <= port_gate_pkg::GATE_RESET;
      auto_clock_gating_select <= 1'b0;
      irq_status <= '0;
      irq_enable <= '0;
      rdata <= 32'h0000_0000;
      enable_q <= '0;
      fault_q <= 1'b0;
      mode_q <= port_gate_pkg::MODE_RUN;
      access_s1 <= '0;
      access_s2 <= '0;
    end else begin
      req <= next_req;
      run_port_clock_gate <= next_run;
      sleep_port_clock_gate <= next_sleep;
      deep_sleep_port_clock_gate <= next_deep;
      auto_clock_gating_select <= next_auto;
      irq_status <= next_irq_status;
      irq_enable <= next_irq_enable;
      rdata <= next_rdata;
      enable_q <= active_gate;
      fault_q <= fault;
      mode_q <= POWER_MODE;
      access_s1 <= PORT_ACCESS;
      access_s2 <= access_s1;
    end
  end

  assign HRDATA = rdata;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign PORT_CLOCK_ENABLE = enable_q;
  assign PORT_BUS_FAULT = fault_q;
  assign IRQ = |(irq_status & irq_enable);

  a_enable_follow: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    1'b1 |=> PORT_CLOCK_ENABLE == $past(active_gate)) else $error("enable lags");
  a_gated_off: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    (active_gate == '0) |=> PORT_CLOCK_ENABLE == '0) else $error("port still clocked");
  a_fault_raise: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    |(access_s2 & ~active_gate) |=> PORT_BUS_FAULT) else $error("fault missing");
  a_run_in_force: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    !auto_clock_gating_select |-> active_gate == run_port_clock_gate)
    else $error("run set not used");
  a_sleep_use: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    auto_clock_gating_select && POWER_MODE == port_gate_pkg::MODE_SLEEP
    |-> active_gate == sleep_port_clock_gate) else $error("sleep set not used");
  a_deep_use: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    auto_clock_gating_select && POWER_MODE == port_gate_pkg::MODE_DEEP_SLEEP
    |-> active_gate == deep_sleep_port_clock_gate) else $error("deep set not used");
  a_run_mode: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    POWER_MODE == port_gate_pkg::MODE_RUN |-> active_gate == run_port_clock_gate)
    else $error("run mode set wrong");
  a_write_bit0: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    req.sel && req.write && req.addr == port_gate_pkg::RUN_PORT_CLOCK_GATE_OFF
    |=> run_port_clock_gate[0] == $past(HWDATA[0])) else $error("port a bit wrong");
  a_upper_zero: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    ##1 $past(next_req.sel && !HWRITE && HADDR[11:0] == port_gate_pkg::RUN_PORT_CLOCK_GATE_OFF)
    |-> HRDATA[31:8] == 24'h000000) else $error("upper bits not zero");

  // write paths of the mode registers and the auto gating bit
  a_sleep_write: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    req.sel && req.write && req.addr == port_gate_pkg::SLEEP_PORT_CLOCK_GATE_OFF
    |=> sleep_port_clock_gate == $past(HWDATA[PORTS-1:0])) else $error("sleep write lost");
  a_deep_write: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    req.sel && req.write && req.addr == port_gate_pkg::DEEP_SLEEP_PORT_CLOCK_GATE_OFF
    |=> deep_sleep_port_clock_gate == $past(HWDATA[PORTS-1:0])) else $error("deep write lost");
  a_auto_write: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    req.sel && req.write && req.addr == port_gate_pkg::RUN_CLOCK_CONFIGURATION_OFF
    |=> auto_clock_gating_select == $past(HWDATA[port_gate_pkg::AUTO_CLOCK_GATING_POS]))
    else $error("auto gating write lost");
  // run set only moves on a bus write
  a_run_hold: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    !(req.sel && req.write) |=> $stable(run_port_clock_gate)) else $error("run set moved");
  // fault output only follows a real fault
  a_fault_pulse: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    !fault |=> !PORT_BUS_FAULT) else $error("spurious fault");
  // events set status even against a clear
  a_fault_status: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    fault |=> irq_status[port_gate_pkg::IRQ_FAULT_POS]) else $error("fault status lost");
  a_mode_status: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    mode_change |=> irq_status[port_gate_pkg::IRQ_MODE_POS]) else $error("mode status lost");
  // bus answers: no wait states, always okay, idle data zero
  a_ready_high: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    HREADYOUT) else $error("ready low");
  a_resp_okay: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    !HRESP) else $error("response not okay");
  a_rdata_idle: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    ##1 !$past(next_req.sel) |-> HRDATA == 32'h0000_0000) else $error("idle read data");
endmodule : port_clock_gating

// File: port_gate_pkg.sv
// constants and types shared by the port clock gating block
package port_gate_pkg;
  localparam int PORT_COUNT = 8;
  localparam logic [11:0] RUN_PORT_CLOCK_GATE_OFF = 12'h108;
  localparam logic [11:0] SLEEP_PORT_CLOCK_GATE_OFF = 12'h118;
  localparam logic [11:0] DEEP_SLEEP_PORT_CLOCK_GATE_OFF = 12'h128;
  localparam logic [11:0] RUN_CLOCK_CONFIGURATION_OFF = 12'h060;
  localparam logic [11:0] IRQ_STATUS_OFF = 12'h200;
  localparam logic [11:0] IRQ_ENABLE_OFF = 12'h204;
  localparam logic [11:0] IRQ_CLEAR_OFF = 12'h208;
  localparam int AUTO_CLOCK_GATING_POS = 27;
  localparam logic [7:0] GATE_RESET = 8'h00;
  localparam int IRQ_BITS = 2;
  localparam int IRQ_FAULT_POS = 0;
  localparam int IRQ_MODE_POS = 1;
  typedef enum logic [1:0] {MODE_RUN, MODE_SLEEP, MODE_DEEP_SLEEP} power_mode_t;
  typedef struct packed {
    logic sel;
    logic write;
    logic [11:0] addr;
  } bus_req_t;
endpackage : port_gate_pkg

// File: port_gate_select.sv
// picks the enable set in force for the current power mode
`timescale 1ns/1ps
module port_gate_select #(
  parameter int PORTS = 8
) (
  input wire logic [PORTS-1:0] run_gate,
  input wire logic [PORTS-1:0] sleep_gate,
  input wire logic [PORTS-1:0] deep_gate,
  input wire logic auto_gating,
  input wire port_gate_pkg::power_mode_t mode,
  output logic [PORTS-1:0] active_gate
);
  always_comb begin
    active_gate = run_gate;
    if (auto_gating) begin
      case (mode)
        port_gate_pkg::MODE_SLEEP: active_gate = sleep_gate;
        port_gate_pkg::MODE_DEEP_SLEEP: active_gate = deep_gate;
        default: active_gate = run_gate;
      endcase
    end
  end
endmodule : port_gate_select

// File: port_fault_check.sv
// flags a port access whose clock is currently off
`timescale 1ns/1ps
module port_fault_check #(
  parameter int PORTS = 8
) (
  input wire logic [PORTS-1:0] access,
  input wire logic [PORTS-1:0] active_gate,
  output logic fault
);
  always_comb begin
    fault = |(access & ~active_gate);
  end
endmodule : port_fault_check

// File: port_clock_gating_tb.sv
// self-checking bench for the port clock gating register block
`timescale 1ns/1ps
module port_clock_gating_tb;
  logic CLOCK = 1'b0;
  logic RESET_N = 1'b0;
  logic HSEL = 1'b0;
  logic [31:0] HADDR = 32'h0;
  logic [1:0] HTRANS = 2'h0;
  logic HWRITE = 1'b0;
  logic [2:0] HSIZE = 3'h2;
  logic [31:0] HWDATA = 32'h0;
  logic HREADY;
  logic [31:0] HRDATA;
  logic HREADYOUT;
  logic HRESP;
  port_gate_pkg::power_mode_t POWER_MODE = port_gate_pkg::MODE_RUN;
  logic [7:0] PORT_CLOCK_ENABLE;
  logic [7:0] PORT_ACCESS = 8'h00;
  logic PORT_BUS_FAULT;
  logic IRQ;
  int failures = 0;
  int check_count = 0;
  logic [31:0] rd;
  assign HREADY = HREADYOUT;
  always #5 CLOCK = ~CLOCK;
  port_clock_gating #(.PORTS(8)) port_clock_gating_i (.CLOCK(CLOCK), .RESET_N(RESET_N),
    .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
    .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .POWER_MODE(POWER_MODE), .PORT_CLOCK_ENABLE(PORT_CLOCK_ENABLE),
    .PORT_ACCESS(PORT_ACCESS), .PORT_BUS_FAULT(PORT_BUS_FAULT), .IRQ(IRQ));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h", $time, what, got);
    end
  endtask : chk
  // one single transfer, address phase then data phase
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= {20'h0, a};
    HWRITE <= wr;
    @(posedge CLOCK);
    while (HREADYOUT !== 1'b1) @(posedge CLOCK);
    HTRANS <= 2'h0;
    HSEL <= 1'b0;
    HWDATA <= wr ? d : 32'h0;
    @(posedge CLOCK);
    while (HREADYOUT !== 1'b1) @(posedge CLOCK);
    rd = HRDATA;
  endtask : xfer
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp, what);
    chk({30'h0, HREADYOUT, HRESP}, 32'h2, "bus response");
  endtask : rd_chk
  task automatic mode_chk(input port_gate_pkg::power_mode_t m, input logic [7:0] exp);
    POWER_MODE <= m;
    repeat (3) @(posedge CLOCK);
    chk({24'h0, PORT_CLOCK_ENABLE}, {24'h0, exp}, "port clock enables");
  endtask : mode_chk
  task automatic t_reset;
    rd_chk(port_gate_pkg::RUN_PORT_CLOCK_GATE_OFF, 32'h0, "run gate reset");
    rd_chk(port_gate_pkg::SLEEP_PORT_CLOCK_GATE_OFF, 32'h0, "sleep gate reset");
    rd_chk(port_gate_pkg::DEEP_SLEEP_PORT_CLOCK_GATE_OFF, 32'h0, "deep gate reset");
    chk({24'h0, PORT_CLOCK_ENABLE}, 32'h0, "enables after reset");
  endtask : t_reset
  task automatic t_layout;
    xfer(1'b1, port_gate_pkg::RUN_PORT_CLOCK_GATE_OFF, 32'hFFFFFFFF);
    rd_chk(port_gate_pkg::RUN_PORT_CLOCK_GATE_OFF, 32'h000000FF, "upper bits");
    xfer(1'b1, port_gate_pkg::SLEEP_PORT_CLOCK_GATE_OFF, 32'hFFFF00A5);
    rd_chk(port_gate_pkg::SLEEP_PORT_CLOCK_GATE_OFF, 32'h000000A5, "sleep gate");
    xfer(1'b1, port_gate_pkg::DEEP_SLEEP_PORT_CLOCK_GATE_OFF, 32'h0000003C);
    rd_chk(port_gate_pkg::DEEP_SLEEP_PORT_CLOCK_GATE_OFF, 32'h0000003C, "deep gate");
    xfer(1'b1, 12'h300, 32'hFFFFFFFF);
    rd_chk(12'h300, 32'h0, "unmapped read");
  endtask : t_layout
  task automatic t_run;
    xfer(1'b1, port_gate_pkg::RUN_PORT_CLOCK_GATE_OFF, 32'h00000001);
    mode_chk(port_gate_pkg::MODE_RUN, 8'h01);
    xfer(1'b1, port_gate_pkg::RUN_PORT_CLOCK_GATE_OFF, 32'h00000080);
    mode_chk(port_gate_pkg::MODE_RUN, 8'h80);
    xfer(1'b1, port_gate_pkg::RUN_PORT_CLOCK_GATE_OFF, 32'h0000000F);
  endtask : t_run
  task automatic t_modes;
    mode_chk(port_gate_pkg::MODE_SLEEP, 8'h0F);
    mode_chk(port_gate_pkg::MODE_DEEP_SLEEP, 8'h0F);
    xfer(1'b1, port_gate_pkg::RUN_CLOCK_CONFIGURATION_OFF, 32'h08000000);
    mode_chk(port_gate_pkg::MODE_DEEP_SLEEP, 8'h3C);
    mode_chk(port_gate_pkg::MODE_SLEEP, 8'hA5);
    mode_chk(port_gate_pkg::MODE_RUN, 8'h0F);
    xfer(1'b1, port_gate_pkg::RUN_CLOCK_CONFIGURATION_OFF, 32'h0);
  endtask : t_modes
  // pulse one port access and count fault cycles
  task automatic access_chk(input logic [7:0] acc, input int exp);
    int n;
    n = 0;
    PORT_ACCESS <= acc;
    @(posedge CLOCK);
    PORT_ACCESS <= 8'h00;
    repeat (8) begin
      @(posedge CLOCK);
      if (PORT_BUS_FAULT === 1'b1) n++;
    end
    chk(n, exp, "fault cycles");
  endtask : access_chk
  task automatic t_fault;
    xfer(1'b1, port_gate_pkg::IRQ_CLEAR_OFF, 32'h00000003);
    xfer(1'b1, port_gate_pkg::IRQ_ENABLE_OFF, 32'h00000001);
    access_chk(8'h01, 0);
    chk({31'h0, IRQ}, 32'h0, "irq quiet");
    access_chk(8'h80, 1);
    chk({31'h0, IRQ}, 32'h1, "irq raised");
    rd_chk(port_gate_pkg::IRQ_STATUS_OFF, 32'h00000001, "fault status");
    xfer(1'b1, port_gate_pkg::IRQ_ENABLE_OFF, 32'h0);
    repeat (2) @(posedge CLOCK);
    chk({31'h0, IRQ}, 32'h0, "irq masked");
    xfer(1'b1, port_gate_pkg::IRQ_ENABLE_OFF, 32'h1);
    xfer(1'b1, port_gate_pkg::IRQ_CLEAR_OFF, 32'h1);
    repeat (2) @(posedge CLOCK);
    chk({31'h0, IRQ}, 32'h0, "irq cleared");
    rd_chk(port_gate_pkg::IRQ_STATUS_OFF, 32'h0, "status cleared");
    xfer(1'b1, port_gate_pkg::IRQ_ENABLE_OFF, 32'h2);
    mode_chk(port_gate_pkg::MODE_SLEEP, 8'h0F);
    chk({31'h0, IRQ}, 32'h1, "mode irq raised");
    rd_chk(port_gate_pkg::IRQ_STATUS_OFF, 32'h00000002, "mode status");
    mode_chk(port_gate_pkg::MODE_RUN, 8'h0F);
    xfer(1'b1, port_gate_pkg::IRQ_CLEAR_OFF, 32'h3);
    repeat (2) @(posedge CLOCK);
    chk({31'h0, IRQ}, 32'h0, "mode irq cleared");
  endtask : t_fault
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  initial begin
    #100000;
    failures++;
    results();
  end
  initial begin
    repeat (2) @(posedge CLOCK);
    RESET_N <= 1'b1;
    @(posedge CLOCK);
    t_reset();
    t_layout();
    t_run();
    t_modes();
    t_fault();
    results();
  end
endmodule : port_clock_gating_tb
